// ### efstat_pkg.sv
// Package: counter indices, widths and event carriers for the frame statistics block
package efstat_pkg;

  // Counter widths
  localparam int WIDE_CNT_W   = 32;
  localparam int NARROW_CNT_W = 20;
  localparam int UNDOC_CNT_W  = 20;
  localparam int SNAP_W       = 32;

  // Frame length, collision count and counter reset value
  localparam int            LEN_W        = 14;
  localparam logic [13:0]   RUNT_LEN     = 14'h0040;
  localparam int            TX_COLL_W    = 4;
  localparam logic [3:0]    ONE_COLL     = 4'h1;
  localparam logic [31:0]   CNT_RST_VAL  = 32'h0000_0000;

  // Counter indices
  localparam int NUM_CNT        = 19;
  localparam int IX_RX_GOOD     = 0;
  localparam int IX_RX_CRC      = 1;
  localparam int IX_RX_RUNT     = 2;
  localparam int IX_RX_ALIGN    = 3;
  localparam int IX_RX_LONG     = 4;
  localparam int IX_RX_LATE     = 5;
  localparam int IX_RX_BAD      = 6;
  localparam int IX_RX_DROP     = 7;
  localparam int IX_TX_GOOD     = 8;
  localparam int IX_TX_PAUSE    = 9;
  localparam int IX_TX_SINGLE   = 10;
  localparam int IX_TX_MULTI    = 11;
  localparam int IX_TX_EXCOLL   = 12;
  localparam int IX_TX_LATE     = 13;
  localparam int IX_TX_UNDERRUN = 14;
  localparam int IX_TX_DEFER    = 15;
  localparam int IX_TX_CARRIER  = 16;
  localparam int IX_TX_BAD      = 17;
  localparam int IX_SPARE       = 18;

  // Receive status event, one-cycle valid per frame
  typedef struct packed {
    logic             valid;
    logic             crc_err;
    logic             dribble;
    logic             late_coll;
    logic             mii_err;
    logic             dropped;
    logic [LEN_W-1:0] frame_len;
  } efstat_rx_s;

  // Transmit status event, one-cycle valid per frame
  typedef struct packed {
    logic                 valid;
    logic                 pause;
    logic [TX_COLL_W-1:0] coll_cnt;
    logic                 exc_coll;
    logic                 late_coll;
    logic                 underrun;
    logic                 exc_defer;
    logic                 carrier_err;
  } efstat_tx_s;

  typedef logic [SNAP_W-1:0] efstat_word_t;

endpackage : efstat_pkg

// ### efstat_top.sv
// Frame statistics counters with one-shot snapshot read for the control logic
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Single counter, wrapping or saturating with read-clear

module efstat_counter #(
  parameter int W   = 20,
  parameter bit SAT = 1'b1
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rstn,
  input  wire logic         i_inc,
  input  wire logic         i_clr,
  output logic [W-1:0]      o_cnt
);

  logic [W-1:0] cnt_q;

  // A set in the clearing cycle wins, so the frame is not lost
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (SAT && i_clr) begin
      cnt_q <= W'(i_inc);
    end else if (i_inc) begin
      if (SAT && (&cnt_q)) begin
        cnt_q <= cnt_q;
      end else begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end

  assign o_cnt = cnt_q;

endmodule : efstat_counter

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - 32-bit good receive count, includes good frames later dropped by FIFO controller.
// - Receive CRC counter: CRC flag set and dribbling flag clear.
// - Runt counter: received frame under 64 bytes with CRC error.
// - 20-bit alignment counter: CRC flag and dribbling flag both set.
// - Oversize counter: frame longer than programmed maximum frame size.
// - Receive late collision counter: MAC reported a late collision.
// - Receive bad counter: any errored frame, excluding FIFO-dropped frames.
// - Dropped counter: frame discarded for lack of receive FIFO room.
// - Dropped errored frame bumps only the dropped counter.
// - 32-bit good transmit count, pause frames excluded.
// - 20-bit counter of successfully sent pause frames.
// - 20-bit counter of frames sent after exactly one collision.
// - 20-bit counter of frames sent after two or more collisions.
// - Count transmit frames aborted for excessive collisions.
// - 20-bit counter of transmit aborts from late collision.
// - 20-bit counter of transmit aborts from buffer underrun.
// - Count transmit frames aborted for excessive deferral.
// - Carrier error counter: carrier lost or never present during transmit.
// - Transmit bad counter: every transmitted frame ending with any error.
// - Control logic reads all counters at once through the statistics request.
// - First variant: counters saturate and clear when read.
// - Second variant: snapshot on request, counters wrap and never clear.
module efstat_top #(
  parameter bit P_SNAP_MODE = 1'b0,
  parameter int P_UNDOC_W   = efstat_pkg::UNDOC_CNT_W
) (
  input  wire logic                                   i_clk_sys,
  input  wire logic                                   i_rstn,
  input  wire efstat_pkg::efstat_rx_s                 i_rx_stat,
  input  wire efstat_pkg::efstat_tx_s                 i_tx_stat,
  input  wire logic [efstat_pkg::LEN_W-1:0]           i_max_frame_len,
  input  wire logic                                   i_stat_req,
  output logic                                        o_stat_valid,
  output efstat_pkg::efstat_word_t                    o_stat_data [efstat_pkg::NUM_CNT]
);

  localparam int N = efstat_pkg::NUM_CNT;
  localparam efstat_pkg::efstat_word_t UNDOC_MAX = efstat_pkg::efstat_word_t'((64'h1 << P_UNDOC_W) - 64'h1);

  logic [N-1:0]                 inc;
  efstat_pkg::efstat_word_t     cnt [N];
  efstat_pkg::efstat_word_t     snap_q [N];
  logic                         stat_valid_q;
  logic                         rx_err_any;
  logic                         rx_long;
  logic                         rx_count_err;
  logic                         tx_abort;
  logic                         tx_err_any;
  logic                         tx_ok;

  //////////////////////////////////////////////////////////////////////////////
  // Receive event decode

  assign rx_long      = i_rx_stat.frame_len > i_max_frame_len;
  assign rx_err_any   = i_rx_stat.crc_err | i_rx_stat.late_coll | i_rx_stat.mii_err | rx_long;
  // Dropped frames are kept out of every receive error counter
  assign rx_count_err = i_rx_stat.valid & ~i_rx_stat.dropped;

  always_comb begin
    inc = '0;
    inc[efstat_pkg::IX_RX_GOOD]  = i_rx_stat.valid & ~rx_err_any;
    inc[efstat_pkg::IX_RX_CRC]   = rx_count_err & i_rx_stat.crc_err & ~i_rx_stat.dribble;
    inc[efstat_pkg::IX_RX_RUNT]  = rx_count_err & i_rx_stat.crc_err
                                   & (i_rx_stat.frame_len < efstat_pkg::RUNT_LEN);
    inc[efstat_pkg::IX_RX_ALIGN] = rx_count_err & i_rx_stat.crc_err & i_rx_stat.dribble;
    inc[efstat_pkg::IX_RX_LONG]  = rx_count_err & rx_long;
    inc[efstat_pkg::IX_RX_LATE]  = rx_count_err & i_rx_stat.late_coll;
    inc[efstat_pkg::IX_RX_BAD]   = rx_count_err & rx_err_any;
    inc[efstat_pkg::IX_RX_DROP]  = i_rx_stat.valid & i_rx_stat.dropped;
    // Transmit side
    inc[efstat_pkg::IX_TX_GOOD]     = tx_ok & ~i_tx_stat.pause;
    inc[efstat_pkg::IX_TX_PAUSE]    = tx_ok & i_tx_stat.pause;
    inc[efstat_pkg::IX_TX_SINGLE]   = tx_ok & (i_tx_stat.coll_cnt == efstat_pkg::ONE_COLL);
    inc[efstat_pkg::IX_TX_MULTI]    = tx_ok & (i_tx_stat.coll_cnt > efstat_pkg::ONE_COLL);
    inc[efstat_pkg::IX_TX_EXCOLL]   = i_tx_stat.valid & i_tx_stat.exc_coll;
    inc[efstat_pkg::IX_TX_LATE]     = i_tx_stat.valid & i_tx_stat.late_coll;
    inc[efstat_pkg::IX_TX_UNDERRUN] = i_tx_stat.valid & i_tx_stat.underrun;
    inc[efstat_pkg::IX_TX_DEFER]    = i_tx_stat.valid & i_tx_stat.exc_defer;
    inc[efstat_pkg::IX_TX_CARRIER]  = i_tx_stat.valid & i_tx_stat.carrier_err;
    inc[efstat_pkg::IX_TX_BAD]      = i_tx_stat.valid & tx_err_any;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit event decode

  // Carrier loss does not abort, but the frame still counts as errored
  assign tx_abort   = i_tx_stat.exc_coll | i_tx_stat.late_coll | i_tx_stat.underrun
                      | i_tx_stat.exc_defer;
  assign tx_err_any = tx_abort | i_tx_stat.carrier_err;
  assign tx_ok      = i_tx_stat.valid & ~tx_err_any;

  //////////////////////////////////////////////////////////////////////////////
  // Counter bank

  generate
    for (genvar g = 0; g < N; g++) begin : g_cnt
      localparam int CW = (g == efstat_pkg::IX_RX_GOOD || g == efstat_pkg::IX_TX_GOOD)
                          ? efstat_pkg::WIDE_CNT_W
                          : ((g == efstat_pkg::IX_RX_ALIGN || g == efstat_pkg::IX_TX_PAUSE
                              || g == efstat_pkg::IX_TX_SINGLE || g == efstat_pkg::IX_TX_MULTI
                              || g == efstat_pkg::IX_TX_LATE
                              || g == efstat_pkg::IX_TX_UNDERRUN)
                             ? efstat_pkg::NARROW_CNT_W : P_UNDOC_W);
      logic [CW-1:0] val;
      efstat_counter #(
        .W   (CW),
        .SAT (!P_SNAP_MODE)
      ) u_cnt (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_inc     (inc[g]),
        .i_clr     (i_stat_req),
        .o_cnt     (val)
      );
      assign cnt[g] = efstat_pkg::efstat_word_t'(val);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Snapshot for the statistics request

  // Whole set captured on one edge so the host sees a coherent picture
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      for (int k = 0; k < N; k++) begin
        snap_q[k] <= efstat_pkg::CNT_RST_VAL;
      end
    end else if (i_stat_req) begin
      for (int k = 0; k < N; k++) begin
        snap_q[k] <= cnt[k];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      stat_valid_q <= 1'b0;
    end else begin
      stat_valid_q <= i_stat_req;
    end
  end

  assign o_stat_valid = stat_valid_q;
  assign o_stat_data  = snap_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  rx_good_a: assert property (i_rx_stat.valid && !rx_err_any && i_rx_stat.dropped
                              |-> inc[efstat_pkg::IX_RX_GOOD])
    else $error("dropped good frame not counted as good");
  crc_split_a: assert property (rx_count_err && i_rx_stat.crc_err
                                |-> (inc[efstat_pkg::IX_RX_CRC] != inc[efstat_pkg::IX_RX_ALIGN]))
    else $error("CRC and alignment counters not exclusive");
  runt_len_a: assert property (inc[efstat_pkg::IX_RX_RUNT]
                               |-> i_rx_stat.frame_len < efstat_pkg::RUNT_LEN && i_rx_stat.crc_err)
    else $error("runt counted without short CRC-errored frame");
  drop_only_a: assert property (i_rx_stat.valid && i_rx_stat.dropped
                                |-> inc[7:1] == 7'h40)
    else $error("dropped frame reached a receive error counter");
  pause_excl_a: assert property (inc[efstat_pkg::IX_TX_PAUSE]
                                 |-> !inc[efstat_pkg::IX_TX_GOOD])
    else $error("pause frame counted as good transmit");
  tx_bad_a: assert property (i_tx_stat.valid && i_tx_stat.carrier_err
                             |-> inc[efstat_pkg::IX_TX_BAD] && !inc[efstat_pkg::IX_TX_GOOD])
    else $error("carrier error frame not counted as bad");
  snap_data_a: assert property (i_stat_req
                                |=> o_stat_valid && o_stat_data[0] == $past(cnt[0]))
    else $error("snapshot does not match counter at request");
  read_clr_a: assert property (!P_SNAP_MODE && i_stat_req
                               |=> cnt[efstat_pkg::IX_TX_BAD] == 32'($past(inc[17])))
    else $error("counter not cleared by read");
  no_clr_a: assert property (P_SNAP_MODE && i_stat_req && !inc[efstat_pkg::IX_RX_GOOD]
                             |=> cnt[0] == $past(cnt[0]))
    else $error("counter changed on read in snapshot variant");
  step_a: assert property (inc[efstat_pkg::IX_TX_GOOD] && !i_stat_req
                           && cnt[efstat_pkg::IX_TX_GOOD] != 32'hFFFF_FFFF
                           |=> cnt[8] == $past(cnt[8]) + 32'h0000_0001)
    else $error("good transmit counter did not step by one");

  //////////////////////////////////////////////////////////////////////////////
  // Decode checks look at the raw flags, so a slip in the shared error terms shows up

  rx_good_err_a: assert property (inc[efstat_pkg::IX_RX_GOOD]
                                  |-> i_rx_stat.valid && !i_rx_stat.crc_err && !i_rx_stat.mii_err)
    else $error("errored frame counted as good");

  crc_only_a: assert property (inc[efstat_pkg::IX_RX_CRC]
                               |-> i_rx_stat.crc_err && !i_rx_stat.dribble && !i_rx_stat.dropped)
    else $error("CRC counter bumped without a plain CRC error");

  crc_count_a: assert property (i_rx_stat.valid && i_rx_stat.crc_err && !i_rx_stat.dribble
                                && !i_rx_stat.dropped |-> inc[efstat_pkg::IX_RX_CRC])
    else $error("plain CRC error not counted");

  runt_count_a: assert property (i_rx_stat.valid && i_rx_stat.crc_err && !i_rx_stat.dropped
                                 && i_rx_stat.frame_len < efstat_pkg::RUNT_LEN
                                 |-> inc[efstat_pkg::IX_RX_RUNT])
    else $error("short CRC-errored frame not counted as runt");

  align_only_a: assert property (inc[efstat_pkg::IX_RX_ALIGN]
                                 |-> i_rx_stat.crc_err && i_rx_stat.dribble)
    else $error("alignment counter bumped without both flags");

  align_count_a: assert property (i_rx_stat.valid && !i_rx_stat.dropped && i_rx_stat.crc_err
                                  && i_rx_stat.dribble |-> inc[efstat_pkg::IX_RX_ALIGN])
    else $error("alignment error not counted");

  long_only_a: assert property (inc[efstat_pkg::IX_RX_LONG]
                                |-> i_rx_stat.frame_len > i_max_frame_len)
    else $error("oversize counted for a legal length");

  long_count_a: assert property (i_rx_stat.valid && !i_rx_stat.dropped
                                 && i_rx_stat.frame_len > i_max_frame_len
                                 |-> inc[efstat_pkg::IX_RX_LONG])
    else $error("oversize frame not counted");

  rx_late_a: assert property (i_rx_stat.valid && !i_rx_stat.dropped && i_rx_stat.late_coll
                              |-> inc[efstat_pkg::IX_RX_LATE])
    else $error("receive late collision not counted");

  rx_bad_a: assert property (i_rx_stat.valid && !i_rx_stat.dropped && i_rx_stat.mii_err
                             |-> inc[efstat_pkg::IX_RX_BAD])
    else $error("errored receive frame not counted as bad");

  bad_nodrop_a: assert property (inc[efstat_pkg::IX_RX_BAD]
                                 |-> !i_rx_stat.dropped)
    else $error("dropped frame counted as bad");

  drop_count_a: assert property (inc[efstat_pkg::IX_RX_DROP]
                                 == (i_rx_stat.valid && i_rx_stat.dropped))
    else $error("dropped counter disagrees with drop flag");

  tx_good_a: assert property (i_tx_stat.valid && !i_tx_stat.pause && !i_tx_stat.exc_coll
                              && !i_tx_stat.late_coll && !i_tx_stat.underrun
                              && !i_tx_stat.exc_defer && !i_tx_stat.carrier_err
                              |-> inc[efstat_pkg::IX_TX_GOOD])
    else $error("clean transmit frame not counted");

  pause_count_a: assert property (inc[efstat_pkg::IX_TX_PAUSE]
                                  |-> i_tx_stat.valid && i_tx_stat.pause && !i_tx_stat.underrun)
    else $error("pause counter bumped without a clean pause frame");

  single_coll_a: assert property (inc[efstat_pkg::IX_TX_SINGLE]
                                  |-> i_tx_stat.coll_cnt == efstat_pkg::ONE_COLL)
    else $error("single collision counted with another count");

  multi_coll_a: assert property (inc[efstat_pkg::IX_TX_MULTI]
                                 |-> i_tx_stat.coll_cnt > efstat_pkg::ONE_COLL)
    else $error("multiple collision counted with too few");

  excoll_count_a: assert property (i_tx_stat.valid && i_tx_stat.exc_coll
                                   |-> inc[efstat_pkg::IX_TX_EXCOLL] && inc[efstat_pkg::IX_TX_BAD])
    else $error("excessive collision abort not counted");

  tx_late_a: assert property (i_tx_stat.valid && i_tx_stat.late_coll
                              |-> inc[efstat_pkg::IX_TX_LATE] && !inc[efstat_pkg::IX_TX_GOOD])
    else $error("late collision abort not counted");

  underrun_count_a: assert property (i_tx_stat.valid && i_tx_stat.underrun
                                     |-> inc[efstat_pkg::IX_TX_UNDERRUN])
    else $error("underrun abort not counted");

  defer_count_a: assert property (i_tx_stat.valid && i_tx_stat.exc_defer
                                  |-> inc[efstat_pkg::IX_TX_DEFER])
    else $error("excessive deferral abort not counted");

  carrier_count_a: assert property (i_tx_stat.valid && i_tx_stat.carrier_err
                                    |-> inc[efstat_pkg::IX_TX_CARRIER])
    else $error("carrier error not counted");

  tx_idle_a: assert property (!i_tx_stat.valid
                              |-> inc[efstat_pkg::IX_TX_BAD:efstat_pkg::IX_TX_GOOD] == 10'h000)
    else $error("transmit counter bumped without a frame");

  rx_idle_a: assert property (!i_rx_stat.valid
                              |-> inc[efstat_pkg::IX_RX_DROP:efstat_pkg::IX_RX_GOOD] == 8'h00)
    else $error("receive counter bumped without a frame");

  valid_pulse_a: assert property (o_stat_valid
                                  |-> $past(i_stat_req))
    else $error("statistics valid without a request");

  snap_hold_a: assert property (!i_stat_req
                                |=> o_stat_data[17] == $past(o_stat_data[17]))
    else $error("snapshot changed without a request");

  sat_hold_a: assert property (!P_SNAP_MODE && cnt[efstat_pkg::IX_RX_CRC] == UNDOC_MAX && !i_stat_req
                               |=> cnt[efstat_pkg::IX_RX_CRC] == UNDOC_MAX)
    else $error("saturated counter moved");

  wrap_a: assert property (P_SNAP_MODE && cnt[efstat_pkg::IX_RX_CRC] == UNDOC_MAX
                           && inc[efstat_pkg::IX_RX_CRC] |=> cnt[efstat_pkg::IX_RX_CRC] == 32'h0000_0000)
    else $error("counter did not wrap to zero");

  spare_zero_a: assert property (cnt[efstat_pkg::IX_SPARE]
                                 == 32'h0000_0000)
    else $error("spare counter is not zero");

  multi_inc_a: assert property (inc[1] && inc[2] && !i_stat_req && cnt[1] != UNDOC_MAX && cnt[2] != UNDOC_MAX
                                |=> cnt[1] == $past(cnt[1]) + 32'h0000_0001 && cnt[2] == $past(cnt[2]) + 32'h0000_0001)
    else $error("coincident increments were lost");

  rx_crc_c:   cover property (inc[efstat_pkg::IX_RX_CRC] && inc[efstat_pkg::IX_RX_RUNT]);
  rx_drop_c:  cover property (i_rx_stat.valid && i_rx_stat.dropped && i_rx_stat.crc_err);
  tx_multi_c: cover property (inc[efstat_pkg::IX_TX_MULTI]);
  read_c:     cover property (i_stat_req && |inc);
  sat_c:      cover property (cnt[efstat_pkg::IX_RX_CRC] == UNDOC_MAX && inc[efstat_pkg::IX_RX_CRC]);

endmodule : efstat_top

// ### efstat_host_model.sv
// Partner model: control logic that requests and captures the statistics snapshot
`timescale 1ns/1ps
module efstat_host_model (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rstn,
  input  wire logic                     i_start,
  input  wire logic                     i_stat_valid,
  input  wire efstat_pkg::efstat_word_t i_stat_data [efstat_pkg::NUM_CNT],
  output logic                          o_stat_req,
  output int                            o_reads,
  output efstat_pkg::efstat_word_t      o_snap [efstat_pkg::NUM_CNT]
);
  initial begin
    o_stat_req = 1'b0;
    o_reads    = 0;
  end
  // Request launched just after the edge, one cycle wide
  always @(posedge i_clk_sys) begin
    o_stat_req <= i_start & i_rstn;
    if (i_stat_valid) begin
      o_snap  <= i_stat_data;
      o_reads <= o_reads + 1;
    end
  end
endmodule : efstat_host_model

// ### testbench.sv
// Self-checking testbench for the frame statistics counters, both variants side by side
`timescale 1ns/1ps
module testbench;
  // Narrow undocumented width so saturation and wrap are reachable in a short run
  localparam int UW = 4;
  typedef struct {logic [19:0] rx; logic [10:0] tx; logic [18:0] m;} efstat_row_s;
  logic                     i_clk_sys, i_rstn, start;
  efstat_pkg::efstat_rx_s   rx;
  efstat_pkg::efstat_tx_s   tx;
  logic                     req0, req1, vld0, vld1;
  int                       rd0, rd1, err_total, num_checks;
  efstat_pkg::efstat_word_t dat0 [efstat_pkg::NUM_CNT], dat1 [efstat_pkg::NUM_CNT];
  efstat_pkg::efstat_word_t snp0 [efstat_pkg::NUM_CNT], snp1 [efstat_pkg::NUM_CNT];
  longint                   cnt0 [19], cnt1 [19];
  efstat_row_s              rows [22] = '{
    '{20'h80064, 11'h000, 19'h00001},
    '{20'hC0028, 11'h000, 19'h00046},
    '{20'hE0064, 11'h000, 19'h00048},
    '{20'h80600, 11'h000, 19'h00050},
    '{20'h90064, 11'h000, 19'h00060},
    '{20'h88064, 11'h000, 19'h00040},
    '{20'hC4028, 11'h000, 19'h00080},
    '{20'h84064, 11'h000, 19'h00081},
    '{20'hC0040, 11'h000, 19'h00042},
    '{20'hC003F, 11'h000, 19'h00046},
    '{20'h805EE, 11'h000, 19'h00001},
    '{20'h00000, 11'h400, 19'h00100},
    '{20'h00000, 11'h600, 19'h00200},
    '{20'h00000, 11'h420, 19'h00500},
    '{20'h00000, 11'h440, 19'h00900},
    '{20'h00000, 11'h5E0, 19'h00900},
    '{20'h00000, 11'h410, 19'h21000},
    '{20'h00000, 11'h408, 19'h22000},
    '{20'h00000, 11'h404, 19'h24000},
    '{20'h00000, 11'h402, 19'h28000},
    '{20'h00000, 11'h401, 19'h30000},
    '{20'hC0028, 11'h460, 19'h00946}
  };

  efstat_top #(.P_SNAP_MODE(1'b0), .P_UNDOC_W(UW)) efstat_top_i (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_rx_stat(rx), .i_tx_stat(tx), .i_max_frame_len(14'h05EE),
    .i_stat_req(req0), .o_stat_valid(vld0), .o_stat_data(dat0));
  efstat_top #(.P_SNAP_MODE(1'b1), .P_UNDOC_W(UW)) efstat_top_snap_i (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_rx_stat(rx), .i_tx_stat(tx), .i_max_frame_len(14'h05EE),
    .i_stat_req(req1), .o_stat_valid(vld1), .o_stat_data(dat1));
  efstat_host_model efstat_host_model_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_start(start), .i_stat_valid(vld0), .i_stat_data(dat0), .o_stat_req(req0),
    .o_reads(rd0), .o_snap(snp0));
  efstat_host_model efstat_host_model_snap_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_start(start), .i_stat_valid(vld1), .i_stat_data(dat1), .o_stat_req(req1),
    .o_reads(rd1), .o_snap(snp1));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input efstat_pkg::efstat_word_t got, input efstat_pkg::efstat_word_t exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  function automatic longint lim(input int k);
    int w;
    w = (k == 0 || k == 8) ? 32 : (k inside {3, 9, 10, 11, 13, 14}) ? 20 : UW;
    return (64'h1 << w) - 1;
  endfunction : lim

  task automatic add(input logic [18:0] m, input int n);
    for (int k = 0; k < 19; k++) begin
      cnt0[k] += m[k] ? n : 0;
      cnt1[k] += m[k] ? n : 0;
    end
  endtask : add

  // Back-to-back events, one frame per cycle
  task automatic ev(input logic [19:0] r, input logic [10:0] t, input logic [18:0] m, input int n);
    repeat (n) begin
      @(negedge i_clk_sys);
      rx = r;
      tx = t;
    end
    @(negedge i_clk_sys);
    rx = '0;
    tx = '0;
    add(m, n);
  endtask : ev

  // Read; r is a receive event landing on the same edge as the request
  task automatic rd(input logic [19:0] r, input logic [18:0] m);
    int b0, b1, w;
    b0 = rd0;
    b1 = rd1;
    @(negedge i_clk_sys);
    start = 1'b1;
    @(negedge i_clk_sys);
    start = 1'b0;
    rx = r;
    @(negedge i_clk_sys);
    rx = '0;
    for (w = 0; w < 8 && (rd0 == b0 || rd1 == b1); w++) @(negedge i_clk_sys);
    if (w == 8) begin
      err_total++;
      results();
    end
    for (int k = 0; k < 19; k++) begin
      chk(snp0[k], efstat_pkg::efstat_word_t'(cnt0[k] > lim(k) ? lim(k) : cnt0[k]));
      chk(snp1[k], efstat_pkg::efstat_word_t'(cnt1[k] & lim(k)));
      cnt0[k] = 0;
    end
    add(m, 1);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rstn = 1'b0;
    start = 1'b0;
    rx = '0;
    tx = '0;
    err_total = 0;
    num_checks = 0;
    foreach (cnt0[k]) cnt0[k] = 0;
    foreach (cnt1[k]) cnt1[k] = 0;
    repeat (12) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    rd('0, '0);
    foreach (rows[i]) begin
      ev(rows[i].rx, rows[i].tx, rows[i].m, 1);
      rd('0, '0);
    end
    ev(20'hC0040, 11'h440, 19'h00942, 17);
    rd('0, '0);
    rd(20'h80064, 19'h00001);
    rd('0, '0);
    ev(20'h80064, 11'h400, 19'h00101, 3);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    foreach (cnt0[k]) cnt0[k] = 0;
    foreach (cnt1[k]) cnt1[k] = 0;
    rd('0, '0);
    results();
  end
endmodule : testbench
